//--- design/ctm_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the compact timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Header holds definitions only
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

`define CTM_OFS_CLK_EN_CTRL 12'h000
`define CTM_OFS_MODE_OUT_CTRL 12'h004
`define CTM_OFS_CNT_LOW 12'h008
`define CTM_OFS_CNT_HIGH 12'h00C
`define CTM_OFS_CMPA_LOW 12'h010
`define CTM_OFS_CMPA_HIGH 12'h014
`define CTM_OFS_PERIOD_CMP 12'h018
`define CTM_OFS_STATUS 12'h01C

`define CTM_RST_CLK_EN_CTRL 8'h00
`define CTM_RST_MODE_OUT_CTRL 8'h00
`define CTM_RST_CMP 8'h00

`define CTM_BIT_PAUSE 7
`define CTM_BIT_CKSEL_HI 6
`define CTM_BIT_CKSEL_LO 4
`define CTM_BIT_ON 3
`define CTM_BIT_MODE_HI 7
`define CTM_BIT_MODE_LO 6
`define CTM_BIT_PINF_HI 5
`define CTM_BIT_PINF_LO 4
`define CTM_BIT_INIT_LVL 3
`define CTM_BIT_INVERT 2
`define CTM_BIT_SWAP 1
`define CTM_BIT_CLRSRC 0

`define CTM_STAT_MATCH_A 0
`define CTM_STAT_MATCH_P 1

`define CTM_DIV_SYS4 4
`define CTM_DIV_HIGH16 16
`define CTM_DIV_HIGH64 64

`endif

//--- design/ctm_pkg.sv
// Purpose: Types shared by the compact timer
// Assumes: Constants live in ctm_params.svh
// Notes: Encodings follow the control register fields
package ctm_pkg;

   typedef enum logic [1:0] {
      CTM_MODE_COMPARE = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TIMER = 2'h3
   } ctm_mode_t;

   typedef enum logic [2:0] {
      CTM_CK_SYS_DIV4 = 3'h0,
      CTM_CK_SYS = 3'h1,
      CTM_CK_HIGH_DIV16 = 3'h2,
      CTM_CK_HIGH_DIV64 = 3'h3,
      CTM_CK_LOW_A = 3'h4,
      CTM_CK_LOW_B = 3'h5,
      CTM_CK_EXT_RISE = 3'h6,
      CTM_CK_EXT_FALL = 3'h7
   } ctm_clk_sel_t;

endpackage : ctm_pkg

//--- design/ctm_compact_timer.sv
// Purpose: 16-bit count-up compact timer with two comparators and one output pin, APB slave
// Assumes: Internal clock ticks arrive as single-cycle strobes from clk_sys domain
// Notes: Counting uses count enables on clk_sys; external and low-speed clocks are synchronised
//
// Contract
// - 16-bit up counter; A compares all bits, P compares top eight bits.
// - Counter cleared on counter_on rising; software cannot otherwise change it.
// - Overflow or selected comparator match clears counter; only comparator matches raise a flag, overflow sets none.
// - counter_pause holds the counter; counting resumes from the held value.
// - clock_select picks divided system, high, low-speed or external edge clock.
// - counter_on low stops counting and keeps the counter value.
// - counter_on rising returns the pin to its initial level in compare/PWM modes.
// - Unused bits 2 to 0 of the clock and enable control read as zero.
// - Mode decode: 00 compare, 01 undefined, 10 PWM, 11 timer/counter.
// - Timer/counter mode leaves the pin undefined; pin function bits unused.
// - Compare mode on A match: none, low, high, or toggle per pin function.
// - PWM pin function: inactive, active, waveform, undefined.
// - A match requesting the present initial level gives no visible change.
// - Initial level sets compare-mode start level and PWM active polarity.
// - output_invert inverts the pin, except in timer/counter mode.
// - duty_period_swap chooses which comparator sets PWM period and duty.
// - Clear source: A match, or P match with overflow when P value zero.
// - Clear source ignored in PWM mode.
// - Counter read-only pair, comparator A read/write pair, P single register.
// - P value zero gives 65536 clocks period, otherwise 256 times value.
// - Compare mode flags: source P raises both, source A only A.
// - Low bytes pass a buffer; high-byte write commits, high-byte read latches.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "ctm_params.svh"

module ctm_compact_timer
   import ctm_pkg::*;
#(
   parameter int CNT_WIDTH = 16,
   parameter int HIGH_DIV16 = `CTM_DIV_HIGH16,
   parameter int HIGH_DIV64 = `CTM_DIV_HIGH64
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources
   input wire logic highClkTick,
   input wire logic lowSpeedClk,
   input wire logic extClockPin,
   // Timer output pin and events
   output logic timerOutputPin,
   output logic matchAPulse,
   output logic matchPPulse
);

   // The dividers are fixed-width counters, so only these ratios can be served
   if (CNT_WIDTH != 16 || HIGH_DIV16 != 16 || HIGH_DIV64 != 64) begin : g_paramCheck
      $error("unsupported counter width or high-clock divider");
   end

   logic [7:0] clkEnCtrl_q;
   logic [7:0] modeCtrl_q;
   logic [15:0] counter_q;
   logic [15:0] cmpA_q;
   logic [7:0] cmpP_q;
   logic [7:0] lowBuf_q;
   logic [1:0] statFlags_q;
   logic onPrev_q;
   logic pin_q;
   logic [1:0] sysDiv_q;
   logic [5:0] highDiv_q;
   logic [1:0] extSync_q;
   logic extPrev_q;
   logic [1:0] lowSync_q;
   logic lowPrev_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic matchA_q;
   logic matchP_q;

   logic counterOn;
   logic counterPause;
   ctm_clk_sel_t clkSel;
   ctm_mode_t opMode;
   logic [1:0] pinFunc;
   logic initLevel;
   logic invert;
   logic swap;
   logic clrSrc;
   logic tick;
   logic onRise;
   logic matchA;
   logic matchP;
   logic overflow;
   logic clearCnt;
   logic accessW;
   logic accessR;
   logic hitAddr;
   logic countEn;
   logic selClkEn;
   logic selMode;
   logic selCmpALow;
   logic selCmpAHigh;
   logic selCntHigh;
   logic selPeriod;
   logic selStatus;

   function automatic logic wordHit(input logic [11:0] addr);
      wordHit = (addr == `CTM_OFS_CLK_EN_CTRL) || (addr == `CTM_OFS_MODE_OUT_CTRL) ||
                (addr == `CTM_OFS_CNT_LOW) || (addr == `CTM_OFS_CNT_HIGH) ||
                (addr == `CTM_OFS_CMPA_LOW) || (addr == `CTM_OFS_CMPA_HIGH) ||
                (addr == `CTM_OFS_PERIOD_CMP) || (addr == `CTM_OFS_STATUS);
   endfunction : wordHit

   // Edge of a synchronised level; both flops are already on clk_sys
   function automatic logic edgeSeen(input logic cur, input logic prev, input logic rising);
      edgeSeen = rising ? (cur && !prev) : (!cur && prev);
   endfunction : edgeSeen

   // PWM active while the duty value is above the count
   function automatic logic pwmActive(input logic [15:0] duty, input logic [15:0] count);
      pwmActive = duty > count;
   endfunction : pwmActive

   assign counterOn = clkEnCtrl_q[`CTM_BIT_ON];
   assign counterPause = clkEnCtrl_q[`CTM_BIT_PAUSE];
   assign clkSel = ctm_clk_sel_t'(clkEnCtrl_q[`CTM_BIT_CKSEL_HI:`CTM_BIT_CKSEL_LO]);
   assign opMode = ctm_mode_t'(modeCtrl_q[`CTM_BIT_MODE_HI:`CTM_BIT_MODE_LO]);
   assign pinFunc = modeCtrl_q[`CTM_BIT_PINF_HI:`CTM_BIT_PINF_LO];
   assign initLevel = modeCtrl_q[`CTM_BIT_INIT_LVL];
   assign invert = modeCtrl_q[`CTM_BIT_INVERT];
   assign swap = modeCtrl_q[`CTM_BIT_SWAP];
   assign clrSrc = modeCtrl_q[`CTM_BIT_CLRSRC];

   // Single-cycle APB answer in the access phase
   assign accessW = psel && penable && pwrite && !pready_q;
   assign accessR = psel && penable && !pwrite && !pready_q;
   assign hitAddr = wordHit(paddr);
   assign onRise = counterOn && !onPrev_q;
   // Counting runs only while on and not paused
   assign countEn = counterOn && !counterPause && tick;

   // Register selects shared by the write, buffer and status paths
   assign selClkEn = (paddr == `CTM_OFS_CLK_EN_CTRL);
   assign selMode = (paddr == `CTM_OFS_MODE_OUT_CTRL);
   assign selCmpALow = (paddr == `CTM_OFS_CMPA_LOW);
   assign selCmpAHigh = (paddr == `CTM_OFS_CMPA_HIGH);
   assign selCntHigh = (paddr == `CTM_OFS_CNT_HIGH);
   assign selPeriod = (paddr == `CTM_OFS_PERIOD_CMP);
   assign selStatus = (paddr == `CTM_OFS_STATUS);

   // Clock source dividers and synchronisers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sysDiv_q <= 2'h0;
      end else begin
         sysDiv_q <= sysDiv_q + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         highDiv_q <= 6'h00;
      end else if (highClkTick) begin
         highDiv_q <= highDiv_q + 6'h01;
      end
   end

   // Only the second flop of each synchroniser is read; the first may be metastable
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         extSync_q <= 2'h0;
         extPrev_q <= 1'b0;
         lowSync_q <= 2'h0;
         lowPrev_q <= 1'b0;
      end else begin
         extSync_q <= {extSync_q[0], extClockPin};
         extPrev_q <= extSync_q[1];
         lowSync_q <= {lowSync_q[0], lowSpeedClk};
         lowPrev_q <= lowSync_q[1];
      end
   end

   // At most one count enable per cycle, whichever source is selected
   always_comb begin
      tick = 1'b0;
      unique case (clkSel)
         CTM_CK_SYS_DIV4: tick = (sysDiv_q == 2'h3);
         CTM_CK_SYS: tick = 1'b1;
         CTM_CK_HIGH_DIV16: tick = highClkTick && (highDiv_q[3:0] == 4'(HIGH_DIV16 - 1));
         CTM_CK_HIGH_DIV64: tick = highClkTick && (highDiv_q == 6'(HIGH_DIV64 - 1));
         CTM_CK_LOW_A, CTM_CK_LOW_B: tick = edgeSeen(lowSync_q[1], lowPrev_q, 1'b1);
         CTM_CK_EXT_RISE: tick = edgeSeen(extSync_q[1], extPrev_q, 1'b1);
         CTM_CK_EXT_FALL: tick = edgeSeen(extSync_q[1], extPrev_q, 1'b0);
      endcase
   end

   // Comparators and clear decision
   always_comb begin
      matchA = tick && (counter_q == cmpA_q) && (cmpA_q != 16'h0000);
      // P matches on the last count below P times 256, so the period is exactly P times 256 ticks
      matchP = tick && (counter_q[15:8] == cmpP_q - 8'h01) && (cmpP_q != 8'h00) &&
               (counter_q[7:0] == 8'hFF);
      overflow = tick && (counter_q == 16'hFFFF);
      if (opMode == CTM_MODE_PWM) begin
         clearCnt = swap ? matchA : matchP;
      end else if (clrSrc) begin
         clearCnt = matchA;
      end else begin
         clearCnt = matchP || (overflow && cmpP_q == 8'h00);
      end
   end

   // Counter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         counter_q <= 16'h0000;
         onPrev_q <= 1'b0;
      end else begin
         onPrev_q <= counterOn;
         if (onRise) begin
            counter_q <= 16'h0000;
         end else if (countEn) begin
            counter_q <= clearCnt ? 16'h0000 : counter_q + 16'h0001;
         end
      end
   end

   // Match events and sticky status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         matchA_q <= 1'b0;
         matchP_q <= 1'b0;
      end else begin
         // P stays silent in compare and timer modes when A is the clear source
         matchA_q <= countEn && matchA;
         matchP_q <= countEn && matchP &&
                     ((opMode == CTM_MODE_PWM) || !clrSrc);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         statFlags_q <= 2'h0;
      end else begin
         // Set wins over a software clear in the same cycle
         statFlags_q <= (statFlags_q & ~((accessW && pstrb[0] && selStatus) ? pwdata[1:0] : 2'h0)) |
                        {matchP_q, matchA_q};
      end
   end

   // Output pin
   // Moves one cycle after the match flag, so flag and pin stay in step
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_q <= 1'b0;
      end else if (onRise && opMode != CTM_MODE_TIMER) begin
         pin_q <= initLevel;
      end else if (opMode == CTM_MODE_COMPARE) begin
         if (matchA_q) begin
            unique case (pinFunc)
               2'h0: pin_q <= pin_q;
               2'h1: pin_q <= 1'b0;
               2'h2: pin_q <= 1'b1;
               2'h3: pin_q <= !pin_q;
            endcase
         end
      end else if (opMode == CTM_MODE_PWM) begin
         unique case (pinFunc)
            2'h0: pin_q <= !initLevel;
            2'h1: pin_q <= initLevel;
            2'h2: pin_q <= pwmActive(swap ? {cmpP_q, 8'h00} : cmpA_q, counter_q) ? initLevel : !initLevel;
            2'h3: pin_q <= pin_q;
         endcase
      end
   end

   // Inverted in compare and PWM modes, held low in timer/counter mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timerOutputPin <= 1'b0;
      end else begin
         timerOutputPin <= (opMode == CTM_MODE_TIMER) ? 1'b0 : (pin_q ^ invert);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         matchAPulse <= 1'b0;
         matchPPulse <= 1'b0;
      end else begin
         matchAPulse <= matchA_q;
         matchPPulse <= matchP_q;
      end
   end

   // Register writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clkEnCtrl_q <= `CTM_RST_CLK_EN_CTRL;
         modeCtrl_q <= `CTM_RST_MODE_OUT_CTRL;
         cmpA_q <= {`CTM_RST_CMP, `CTM_RST_CMP};
         cmpP_q <= `CTM_RST_CMP;
      end else if (accessW && pstrb[0]) begin
         // Writes with lane 0 clear are dropped without an error
         if (selClkEn) begin
            clkEnCtrl_q <= {pwdata[7:3], 3'h0};
         end
         if (selMode) begin
            modeCtrl_q <= pwdata[7:0];
         end
         if (selCmpAHigh) begin
            cmpA_q <= {pwdata[7:0], lowBuf_q};
         end
         if (selPeriod) begin
            cmpP_q <= pwdata[7:0];
         end
      end
   end

   // Low-byte buffer shared by the counter and comparator A pairs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lowBuf_q <= 8'h00;
      end else if (accessW && pstrb[0] && selCmpALow) begin
         lowBuf_q <= pwdata[7:0];
      end else if (accessR && selCntHigh) begin
         lowBuf_q <= counter_q[7:0];
      end else if (accessR && selCmpAHigh) begin
         lowBuf_q <= cmpA_q[7:0];
      end
   end

   // Read data and response
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !hitAddr;
         prdata_q <= 32'h00000000;
         if (accessR) begin
            unique case (paddr)
               `CTM_OFS_CLK_EN_CTRL: prdata_q <= {24'h000000, clkEnCtrl_q[7:3], 3'h0};
               `CTM_OFS_MODE_OUT_CTRL: prdata_q <= {24'h000000, modeCtrl_q};
               `CTM_OFS_CNT_LOW: prdata_q <= {24'h000000, lowBuf_q};
               `CTM_OFS_CNT_HIGH: prdata_q <= {24'h000000, counter_q[15:8]};
               `CTM_OFS_CMPA_LOW: prdata_q <= {24'h000000, lowBuf_q};
               `CTM_OFS_CMPA_HIGH: prdata_q <= {24'h000000, cmpA_q[15:8]};
               `CTM_OFS_PERIOD_CMP: prdata_q <= {24'h000000, cmpP_q};
               `CTM_OFS_STATUS: prdata_q <= {30'h00000000, statFlags_q};
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

endmodule : ctm_compact_timer

//--- dv/cmt_timer_assertions.sv
// Purpose: Port checks of the compact timer bus and match events
// Assumes: Bound to the timer top, one clock domain
// Notes: A pulses are checked to last one cycle; P bound is 8 quiet cycles
`timescale 1ns/1ps
module cmt_timer_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Events
   input wire logic matchAPulse,
   input wire logic matchPPulse
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_pQuiet;
      !matchPPulse [*8];
   endsequence
   a_ready_follows: assert property (s_access |=> pready)
      else $error("access phase not answered");
   a_ready_cause: assert property (pready |-> psel && $past(penable))
      else $error("ready without access");
   a_err_ready: assert property (pslverr |-> pready && (paddr > 12'h01C || paddr[1:0] != 2'h0))
      else $error("error outside unmapped answer");
   a_err_addr: assert property (pready && (paddr > 12'h01C || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unmapped access not refused");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_ctrl_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[2:0] == 3'h0)
      else $error("unused control bits not zero");
   a_a_single: assert property (matchAPulse |=> !matchAPulse)
      else $error("match A pulse too long");
   a_p_spacing: assert property (matchPPulse |=> s_pQuiet)
      else $error("match P pulses too close");
endmodule : cmt_timer_assertions

//--- dv/cmt_tb.sv
// Purpose: Self-checking bench of the compact timer
// Assumes: Pin clocks toggle every two cycles, the high-clock strobe comes every other cycle
// Notes: Expected periods come from the divider table and compare values
`timescale 1ns/1ps
module tb;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, lowSpeedClk, extClockPin;
   logic highClkTick, timerOutputPin, matchAPulse, matchPPulse, lastErr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [3:0] pstrb;
   logic [1:0] ph_q = 2'h0;
   int mismatches, checks_done, cyc = 0, seed = 48, t0, n, hi, v1, v2;
   int divs[8] = '{4, 1, 32, 128, 4, 4, 4, 4};
   ctm_compact_timer uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .highClkTick(highClkTick), .lowSpeedClk(lowSpeedClk), .extClockPin(extClockPin),
      .timerOutputPin(timerOutputPin), .matchAPulse(matchAPulse), .matchPPulse(matchPPulse));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      ph_q <= ph_q + 2'h1;
      highClkTick <= ph_q[0];
      extClockPin <= ph_q[1];
      lowSpeedClk <= ph_q[1];
   end
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdv = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cnt(output int v);
      apb(1'b0, 12'h00C, 32'h0);
      v = rdv[7:0] << 8;
      apb(1'b0, 12'h008, 32'h0);
      v = v | rdv[7:0];
   endtask : cnt
   task automatic run(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p, input logic [2:0] s);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, {24'h0, c1});
      apb(1'b1, 12'h010, {24'h0, a[7:0]});
      apb(1'b1, 12'h014, {24'h0, a[15:8]});
      apb(1'b1, 12'h018, {24'h0, p});
      apb(1'b1, 12'h01C, 32'h3);
      apb(1'b1, 12'h000, {24'h0, 1'b0, s, 4'h8});
   endtask : run
   task automatic waitEv(input logic p);
      int i;
      for (i = 0; i < 5000; i++) begin
         @(posedge clk_sys);
         if ((p ? matchPPulse : matchAPulse) === 1'b1) break;
      end
      chk(i < 5000, 1'b1);
   endtask : waitEv
   // Interval between two events and pin-high samples over it
   task automatic meas(input logic p);
      waitEv(p);
      t0 = cyc;
      hi = (timerOutputPin === 1'b1);
      for (int i = 0; i < 5000; i++) begin
         @(posedge clk_sys);
         if ((p ? matchPPulse : matchAPulse) === 1'b1) break;
         hi += (timerOutputPin === 1'b1);
      end
      n = cyc - t0;
   endtask : meas
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      end_sim();
   end
   initial begin
      {rst, pstrb} = 5'h1F;
      {psel, penable, pwrite, paddr, pwdata, lastErr} = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd0: begin
         apb(1'b0, 12'h004, 32'h0);
         chk(rdv, 32'h0);
         apb(1'b0, 12'h020, 32'h0);
         chk(lastErr, 1'b1);
         apb(1'b1, 12'h000, 32'hF7);
         apb(1'b0, 12'h000, 32'h0);
         chk(rdv, 32'hF0);
      end
      v1 = rnd();
      apb(1'b1, 12'h010, v1[7:0]);
      apb(1'b1, 12'h014, v1[15:8]);
      apb(1'b1, 12'h010, ~v1[7:0]);
      apb(1'b0, 12'h014, 32'h0);
      chk(rdv, v1[15:8]);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdv, v1[7:0]);
      for (int s = 0; s < 8; s++) begin
         v1 = 1 + (rnd() & 3);
         run(8'hC1, v1[15:0], 8'h0, s[2:0]);
         meas(1'b0);
         chk(n, divs[s] * (v1 + 1));
         chk(timerOutputPin, 1'b0);
      end
      for (int i = 0; i < 16; i++) begin
         run({2'b00, i[1:0], i[2], i[3], 2'b01}, 16'd20, 8'h0, 3'h1);
         repeat (4) @(posedge clk_sys);
         chk(timerOutputPin, i[2] ^ i[3]);
         waitEv(1'b0);
         repeat (4) @(posedge clk_sys);
         chk(timerOutputPin, (i[1:0] == 0 ? i[2] : i[1:0] == 1 ? 1'b0 : i[1:0] == 2 ? 1'b1 : !i[2]) ^ i[3]);
      end
      run(8'hC1, 16'h0, 8'h0, 3'h1);
      apb(1'b1, 12'h000, 32'h98);
      cnt(v1);
      repeat (20) @(posedge clk_sys);
      cnt(v2);
      chk(v2, v1);
      apb(1'b1, 12'h000, 32'h18);
      cnt(v2);
      chk(v2 > v1, 1'b1);
      apb(1'b1, 12'h000, 32'h10);
      cnt(v1);
      repeat (20) @(posedge clk_sys);
      cnt(v2);
      chk(v2, v1);
      apb(1'b1, 12'h000, 32'h18);
      cnt(v2);
      chk(v2 < 16, 1'b1);
      run(8'h00, 16'h0080, 8'h01, 3'h1);
      meas(1'b1);
      chk(n, 256);
      apb(1'b0, 12'h01C, 32'h0);
      chk(rdv, 32'h3);
      run(8'h01, 16'h0180, 8'h01, 3'h1);
      repeat (400) @(posedge clk_sys);
      apb(1'b0, 12'h01C, 32'h0);
      chk(rdv, 32'h1);
      run(8'hA9, 16'd64, 8'h01, 3'h1);
      meas(1'b1);
      chk(n, 256);
      chk(hi, 64);
      for (int i = 0; i < 4; i++) begin
         run({3'b100, i[0], 1'b1, i[1], 2'b00}, 16'd64, 8'h01, 3'h1);
         repeat (50) @(posedge clk_sys);
         chk(timerOutputPin, i[0] ^ i[1]);
      end
      end_sim();
   end
endmodule : tb
bind ctm_compact_timer cmt_timer_assertions chk_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .matchAPulse(matchAPulse), .matchPPulse(matchPPulse));
